// [rtl/rirsp_pkg.sv]
// Package for the reset and interrupt response block
package rirsp_pkg;
  localparam int unsigned RIRSP_MCLK_HZ = 50000000;
  // Least reset hold, in phase-one cycles
  localparam int unsigned RIRSP_RESET_HOLD_H1 = 10;
  localparam logic [4:0] RIRSP_RESET_HOLD_CNT = 5'(RIRSP_RESET_HOLD_H1);
  // Wait states per vector fetch, processor mode
  localparam logic [2:0] RIRSP_WAIT_RESET = 3'h7;
  localparam logic [2:0] RIRSP_WAIT_NONE = 3'h0;
  localparam logic [1:0] RIRSP_VECTOR_FETCHES = 2'h2;
  localparam int unsigned RIRSP_IRQ_LINES = 4;

  typedef enum {
    RIRSP_ST_RESET,
    RIRSP_ST_FETCH,
    RIRSP_ST_WAIT,
    RIRSP_ST_RUN
  } rirsp_state_t;

  // Pin drive group: values and output enables (enable low drives)
  typedef struct packed {
    logic data_oe_n;
    logic addr_oe_n;
    logic strobe;
    logic rw_out;
    logic rw_oe_n;
    logic async_oe_n;
  } rirsp_pins_t;
endpackage
`default_nettype wire

// [rtl/rirsp_top.sv]
// Reset sequencing and interrupt intake for the signal processor
`timescale 1ns/1ps
`default_nettype none

module rirsp_top
  import rirsp_pkg::*;
#(
  parameter int unsigned IRQ_N = RIRSP_IRQ_LINES
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [IRQ_N-1:0] interrupt_request_lines_n,
  input wire logic micro_computer_mode,
  input wire logic fetch_boundary,
  input wire logic ack_decode_start,
  output logic phase_one_clock,
  output logic phase_three_clock,
  output rirsp_pins_t pins,
  output logic interrupt_ack_strobe_n,
  output logic [IRQ_N-1:0] irq_taken,
  output logic vector_fetch,
  output logic [2:0] bus_wait_states,
  output logic core_running
);
  rirsp_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  logic reset_seen_reg, reset_seen_next;
  logic [4:0] hold_reg, hold_next;
  logic [1:0] fetch_reg, fetch_next;
  logic [2:0] wait_reg, wait_next;
  logic [2:0] ws_reg, ws_next;
  rirsp_pins_t pins_reg, pins_next;
  logic ack_reg, ack_next;
  logic vf_reg, vf_next;
  logic ph3_reg, ph3_next;
  logic run_reg, run_next;
  wire [IRQ_N-1:0] irq_taken_w;
  // Phase-one rising edge is when phase_reg goes high
  logic h1_rise, h1_fall;
  logic take_ok;

  assign h1_rise = !phase_reg;
  assign h1_fall = phase_reg;
  // Requests are only taken once the core runs
  assign take_ok = (state_reg == RIRSP_ST_RUN) && fetch_boundary && h1_rise;

  always_comb
  begin
    phase_next = ~phase_reg;
    state_next = state_reg;
    reset_seen_next = reset_seen_reg;
    hold_next = hold_reg;
    fetch_next = fetch_reg;
    wait_next = wait_reg;
    ws_next = ws_reg;
    pins_next = pins_reg;
    ack_next = ack_reg;
    vf_next = 1'b0;
    // Three-phase clock is the complement of phase one
    ph3_next = phase_reg;
    pins_next.async_oe_n = 1'b0;
    case (state_reg)
      RIRSP_ST_RESET:
      begin
        // Sequence starts at next phase-one rise
        if (h1_rise)
        begin
          state_next = RIRSP_ST_FETCH;
          fetch_next = '0;
          ws_next = RIRSP_WAIT_RESET;
          pins_next.rw_oe_n = 1'b0;
        end
      end
      RIRSP_ST_FETCH:
      begin
        if (h1_rise)
        begin
          vf_next = 1'b1;
          pins_next.data_oe_n = 1'b0;
          pins_next.addr_oe_n = 1'b0;
          pins_next.strobe = 1'b0;
          wait_next = micro_computer_mode ? RIRSP_WAIT_NONE : RIRSP_WAIT_RESET;
          state_next = RIRSP_ST_WAIT;
        end
      end
      RIRSP_ST_WAIT:
      begin
        if (h1_rise)
        begin
          if (wait_reg != RIRSP_WAIT_NONE)
            wait_next = wait_reg - 3'h1;
          else
          begin
            pins_next.strobe = 1'b1;
            fetch_next = fetch_reg + 2'h1;
            state_next = (fetch_reg + 2'h1 == RIRSP_VECTOR_FETCHES) ? RIRSP_ST_RUN : RIRSP_ST_FETCH;
          end
        end
      end
      default:
      begin
        if (h1_rise)
        begin
          if (ack_decode_start && ack_reg)
            ack_next = 1'b0;
          // High again at the next phase-one rise, two mclk cycles later unless clk_en stalls
          else
            ack_next = 1'b1;
        end
      end
    endcase
    // Registered so the output comes straight from a flop
    run_next = (state_next == RIRSP_ST_RUN);
    // Reset hold counted in phase-one cycles
    if (h1_rise && hold_reg != RIRSP_RESET_HOLD_CNT)
      hold_next = hold_reg + 5'h1;
    reset_seen_next = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= RIRSP_ST_RESET;
      phase_reg <= 1'b0;
      reset_seen_reg <= 1'b0;
      hold_reg <= '0;
      fetch_reg <= '0;
      wait_reg <= '0;
      ws_reg <= RIRSP_WAIT_RESET;
      pins_reg <= '{data_oe_n: 1'b1, addr_oe_n: 1'b1, strobe: 1'b1, rw_out: 1'b1,
                    rw_oe_n: 1'b1, async_oe_n: 1'b1};
      ack_reg <= 1'b1;
      vf_reg <= 1'b0;
      ph3_reg <= 1'b1;
      run_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      reset_seen_reg <= reset_seen_next;
      hold_reg <= hold_next;
      fetch_reg <= fetch_next;
      wait_reg <= wait_next;
      ws_reg <= ws_next;
      pins_reg <= pins_next;
      ack_reg <= ack_next;
      vf_reg <= vf_next;
      ph3_reg <= ph3_next;
      run_reg <= run_next;
    end
  end

  // Per-line intake, level seen at H1 fall
  for (genvar li = 0; li < IRQ_N; li++)
  begin : g_line
    logic pend_reg, pend_next;
    logic block_reg, block_next;
    logic taken_reg, taken_next;
    logic req;

    assign req = ~interrupt_request_lines_n[li];

    always_comb
    begin
      pend_next = pend_reg;
      block_next = block_reg;
      taken_next = 1'b0;
      if (h1_fall)
      begin
        // Held request stays blocked, counts once
        pend_next = pend_reg | (req & ~block_reg);
        block_next = block_reg & req;
      end
      // Pending kept until a fetch boundary
      if (take_ok)
      begin
        taken_next = pend_reg;
        pend_next = 1'b0;
        block_next = block_reg | pend_reg;
      end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
      begin
        pend_reg <= 1'b0;
        block_reg <= 1'b0;
        taken_reg <= 1'b0;
      end
      else if (clk_en)
      begin
        pend_reg <= pend_next;
        block_reg <= block_next;
        taken_reg <= taken_next;
      end
    end

    assign irq_taken_w[li] = taken_reg;

    // Blocked line must not raise a second request
    a_line_held_once: assert property (@(posedge mclk) disable iff (!resetn)
      clk_en && h1_fall && block_reg && !pend_reg |=> !pend_reg)
      else $error("held request counted twice");
  end

  assign phase_one_clock = phase_reg;
  assign phase_three_clock = ph3_reg;
  assign pins = pins_reg;
  assign interrupt_ack_strobe_n = ack_reg;
  assign irq_taken = irq_taken_w;
  assign vector_fetch = vf_reg;
  assign bus_wait_states = ws_reg;
  assign core_running = run_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ack_one_cycle: assert property (clk_en && $fell(ack_reg) |=> !ack_reg ##1 ack_reg)
    else $error("ack pulse wrong");
  a_ack_rises: assert property ($fell(ack_reg) ##1 clk_en ##1 clk_en |-> ack_reg)
    else $error("ack not released");
  a_ack_only_running: assert property ($fell(ack_reg) |-> state_reg == RIRSP_ST_RUN)
    else $error("ack outside run");
  a_phase_toggle: assert property (clk_en |=> phase_reg != $past(phase_reg))
    else $error("phase not toggling");
  a_irq_boundary: assert property (|irq_taken_w |-> $past(fetch_boundary))
    else $error("irq off boundary");
  a_irq_no_double: assert property (|irq_taken_w ##1 clk_en |-> (irq_taken_w & $past(irq_taken_w)) == '0)
    else $error("irq taken twice");
  a_strobe_in_reset: assert property (state_reg == RIRSP_ST_RESET |-> pins_reg.strobe)
    else $error("strobe low in reset");
  a_wait_reset: assert property (state_reg == RIRSP_ST_RESET |-> ws_reg == RIRSP_WAIT_RESET)
    else $error("wait states wrong");
  a_ack_high_reset: assert property (state_reg != RIRSP_ST_RUN |-> ack_reg)
    else $error("ack low in reset");
  c_reach_run: cover property (state_reg == RIRSP_ST_RUN);
  c_ack_pulse: cover property ($fell(ack_reg));
  // Both phase outputs come from flops
  a_phase_complement: assert property (ph3_reg == !phase_reg)
    else $error("phase clocks not complementary");
  a_bus_parked: assert property (state_reg == RIRSP_ST_RESET |-> pins_reg.data_oe_n && pins_reg.addr_oe_n)
    else $error("bus driven in reset");
  // Async group driven once out of reset
  a_async_driven: assert property (state_reg != RIRSP_ST_RESET |-> !pins_reg.async_oe_n)
    else $error("async group still floating");
  a_rw_high: assert property (state_reg != RIRSP_ST_RESET |-> pins_reg.rw_out && !pins_reg.rw_oe_n)
    else $error("read write not high");
  a_fetch_count: assert property (state_reg == RIRSP_ST_RUN |-> fetch_reg == RIRSP_VECTOR_FETCHES)
    else $error("fetch count wrong");
  a_proc_waits: assert property (clk_en && state_reg == RIRSP_ST_FETCH && h1_rise && !micro_computer_mode
    |=> wait_reg == RIRSP_WAIT_RESET)
    else $error("processor fetch waits wrong");
  a_comp_waits: assert property (clk_en && state_reg == RIRSP_ST_FETCH && h1_rise && micro_computer_mode
    |=> wait_reg == RIRSP_WAIT_NONE)
    else $error("computer fetch waits wrong");
  c_irq_taken: cover property (|irq_taken_w);
  c_slow_fetch: cover property (state_reg == RIRSP_ST_WAIT && wait_reg == RIRSP_WAIT_RESET);
  c_vector_fetch: cover property (vf_reg);
endmodule // rirsp_top

`default_nettype wire

// [tb/rirsp_partner.sv]
// External reset and interrupt source model
`timescale 1ns/1ps
`default_nettype none
module rirsp_partner (
  input wire logic mclk,
  output logic resetn,
  output logic [3:0] irq_n
);
  initial
  begin
    resetn = 1'b0;
    irq_n = 4'hf;
  end
  task automatic hold_reset();
    @(posedge mclk) #2 resetn = 1'b0;
    repeat (20) @(posedge mclk);
    #2 resetn = 1'b1;
  endtask
  task automatic pulse(input int ln);
    @(posedge mclk) #2 irq_n[ln] = 1'b0;
    repeat (2) @(posedge mclk);
    #2 irq_n[ln] = 1'b1;
  endtask
endmodule // rirsp_partner
`default_nettype wire

// [tb/reset_and_interrupt_response_test.sv]
// Self-checking bench for the reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_response_test;
  import rirsp_pkg::*;
  logic mclk = 1'b0;
  logic mode = 1'b0;
  logic fb = 1'b0;
  logic ack_dec = 1'b0;
  logic resetn;
  logic [3:0] irq_n;
  logic ph1, ph3, ack_n, vf, run;
  logic [3:0] taken;
  logic [2:0] waits;
  rirsp_pins_t pins;
  int n_mismatch = 0;
  int checks_done = 0;
  int tick = 0;
  int cp, cc, nf, n;
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  rirsp_partner far (.mclk(mclk), .resetn(resetn), .irq_n(irq_n));
  rirsp_top dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
    .interrupt_request_lines_n(irq_n), .micro_computer_mode(mode),
    .fetch_boundary(fb), .ack_decode_start(ack_dec), .phase_one_clock(ph1),
    .phase_three_clock(ph3), .pins(pins), .interrupt_ack_strobe_n(ack_n),
    .irq_taken(taken), .vector_fetch(vf), .bus_wait_states(waits),
    .core_running(run));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic boot(input logic m, output int cyc);
    mode = m;
    nf = 0;
    cyc = 0;
    fork
      far.hold_reset();
      begin
        repeat (12) @(posedge mclk);
        #5;
        chk({pins.data_oe_n, pins.addr_oe_n}, 8'h03);
        chk(pins.strobe, 8'h01);
        chk(pins.rw_oe_n, 8'h01);
        chk(ack_n, 8'h01);
        chk(pins.async_oe_n, 8'h01);
        chk(waits, 8'h07);
        chk(ph3, {7'h0, ~ph1});
      end
    join
    while (!run && cyc < 300)
    begin
      @(posedge mclk) #1;
      if (vf === 1'b1)
        nf++;
      cyc++;
    end
    chk(nf[7:0], 8'h02);
  endtask
  task automatic count_irq(input int ln, input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(posedge mclk) #1;
      if (taken[ln] === 1'b1)
        n++;
    end
  endtask
  task automatic irq_test();
    fb = 1'b1;
    for (int l = 0; l < 4; l++)
    begin
      fork
        far.pulse(l);
        count_irq(l, 12);
      join
      chk(n[7:0], 8'h01);
    end
    fb = 1'b0;
    fork
      far.pulse(2);
      count_irq(2, 12);
    join
    chk(n[7:0], 8'h00);
    fb = 1'b1;
    count_irq(2, 6);
    chk(n[7:0], 8'h01);
  endtask
  task automatic ack_test();
    n = 0;
    @(posedge mclk) #2 ack_dec = 1'b1;
    repeat (10)
    begin
      @(posedge mclk) #1;
      if (ack_n === 1'b0)
        n++;
      if (n > 0)
        ack_dec = 1'b0;
    end
    chk(n[7:0], 8'h02);
  endtask
  always @(posedge mclk)
  begin
    tick++;
    if (tick == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    boot(1'b0, cp);
    chk(waits, 8'h07);
    boot(1'b1, cc);
    chk(cp >= cc + 14, 8'h01);
    irq_test();
    ack_test();
    finish_test();
  end
endmodule // reset_and_interrupt_response_test
`default_nettype wire
